// ### shared/spindle_status_defines.svh
// Offsets, bit positions and reset values of the spindle status word generator
`ifndef SPINDLE_STATUS_DEFINES_SVH
`define SPINDLE_STATUS_DEFINES_SVH

`define OFS_STATUS_FIVE   12'h000
`define OFS_STATUS_SIX    12'h004
`define OFS_DETECT_SPEED  12'h008
`define OFS_DETECT_HYST   12'h00c
`define OFS_IN_POS_AREA   12'h010
`define OFS_CONTROL       12'h014

`define BIT_SPEED_DETECT  1
`define BIT_EXCITATION    11
`define BIT_SPEED_GAIN    12
`define BIT_REDETECT      13
`define BIT_HOLD_UP       14
`define BIT_IN_POS2       15
`define BIT_FEEDFORWARD   0
`define BIT_INTERDRIVE    8

`define CTRL_EXCITATION   0
`define CTRL_SPEED_GAIN   1
`define CTRL_FEEDFORWARD  2
`define CTRL_INTERDRIVE   3

`define RST_DETECT_SPEED  32'h0000_0000
`define RST_DETECT_HYST   32'h0000_0000
`define RST_IN_POS_AREA   32'h0000_0000
`define RST_CONTROL       4'h0

`endif

// ### shared/spindle_status_pkg.sv
// Types of the spindle status word generator
package spindle_status_pkg;
	typedef enum logic [1:0] {
		resp_okay   = 2'b00,
		resp_slverr = 2'b10
	} axi_resp_type;
	typedef enum {
		redet_idle,
		redet_running,
		redet_done
	} redetect_state_type;
endpackage

// ### design/spindle_status_word_gen.sv
// Spindle status word generator with AXI4-Lite register access
`timescale 1ns/100ps
`include "spindle_status_defines.svh"

module spindle_status_word_gen #(
	parameter int SPEED_W = 32,
	parameter int DROOP_W = 32
) (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// Control core inputs
	input  wire logic signed [SPEED_W-1:0]     motor_speed,
	input  wire logic signed [DROOP_W-1:0]     position_droop,
	input  wire logic                          redetect_request,
	input  wire logic                          redetect_finished,
	input  wire logic                          holding_force_up_request,
	// Status word and re-detection start outputs
	output logic [15:0]                        status_word_five,
	output logic [15:0]                        status_word_six,
	output logic                               redetect_start,
	// AXI4-Lite slave
	input  wire logic [11:0]                   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output spindle_status_pkg::axi_resp_type   s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [11:0]                   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output spindle_status_pkg::axi_resp_type   s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	import spindle_status_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0]        detect_speed_param_q;
	logic [31:0]        detect_hysteresis_param_q;
	logic [31:0]        in_pos_area_param_q;
	logic [3:0]         control_q;
	logic               speed_detect_flag_q;
	logic               speed_detect_flag_d;
	logic               second_in_position_flag_q;
	logic               holding_force_up_answer_q;
	logic               redetect_request_q;
	redetect_state_type redet_state_q;
	redetect_state_type redet_state_d;

	// ****************************************
	// Speed detection with hysteresis
	// ****************************************
	wire logic [SPEED_W-1:0] speed_abs;
	wire logic [32:0]        speed_abs_ext;
	wire logic [32:0]        clear_level;
	wire logic [32:0]        set_level;
	wire logic               speed_above;
	wire logic               speed_below;

	assign speed_abs = motor_speed[SPEED_W-1] ? SPEED_W'(-motor_speed)
		: SPEED_W'(motor_speed);
	assign speed_abs_ext = 33'(speed_abs);
	assign set_level = {1'b0, detect_speed_param_q};
	assign clear_level = {1'b0, detect_speed_param_q}
		+ {1'b0, detect_hysteresis_param_q};
	assign speed_above = speed_abs_ext > clear_level;
	assign speed_below = speed_abs_ext < set_level;

	always_comb begin
		speed_detect_flag_d = speed_detect_flag_q;
		if (speed_above) begin
			speed_detect_flag_d = 1'b0;
		end else if (speed_below) begin
			speed_detect_flag_d = 1'b1;
		end
	end

	// ****************************************
	// Second in-position by droop
	// ****************************************
	wire logic [DROOP_W-1:0] droop_abs;
	wire logic               droop_inside;

	assign droop_abs = position_droop[DROOP_W-1] ? DROOP_W'(-position_droop)
		: DROOP_W'(position_droop);
	assign droop_inside = 33'(droop_abs) <= {1'b0, in_pos_area_param_q};

	// ****************************************
	// Zero point re-detection handshake
	// ****************************************
	wire logic request_rise;
	wire logic redetect_complete_flag;

	assign request_rise = redetect_request && !redetect_request_q;
	assign redetect_start = (redet_state_q == redet_idle) && redetect_request;
	assign redetect_complete_flag = redet_state_q == redet_done;

	always_comb begin
		redet_state_d = redet_state_q;
		case (redet_state_q)
			redet_idle: begin
				if (redetect_request) begin
					redet_state_d = redet_running;
				end
			end
			redet_running: begin
				if (!redetect_request) begin
					redet_state_d = redet_idle;
				end else if (redetect_finished) begin
					redet_state_d = redet_done;
				end
			end
			redet_done: begin
				if (!redetect_request) begin
					redet_state_d = redet_idle;
				end
			end
			default: begin
				redet_state_d = redet_idle;
			end
		endcase
	end

	// ****************************************
	// Status word assembly
	// ****************************************
	wire logic [15:0] word_five_d;
	wire logic [15:0] word_six_d;

	// All other bits stay zero as maintenance bits
	assign word_five_d = (16'(speed_detect_flag_q) << `BIT_SPEED_DETECT)
		| (16'(control_q[`CTRL_EXCITATION]) << `BIT_EXCITATION)
		| (16'(control_q[`CTRL_SPEED_GAIN]) << `BIT_SPEED_GAIN)
		| (16'(redetect_complete_flag) << `BIT_REDETECT)
		| (16'(holding_force_up_answer_q) << `BIT_HOLD_UP)
		| (16'(second_in_position_flag_q) << `BIT_IN_POS2);
	assign word_six_d = (16'(control_q[`CTRL_FEEDFORWARD]) << `BIT_FEEDFORWARD)
		| (16'(control_q[`CTRL_INTERDRIVE]) << `BIT_INTERDRIVE);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			speed_detect_flag_q       <= 1'b0;
			second_in_position_flag_q <= 1'b0;
			holding_force_up_answer_q <= 1'b0;
			redetect_request_q        <= 1'b0;
			redet_state_q             <= redet_idle;
		end else begin
			speed_detect_flag_q       <= speed_detect_flag_d;
			second_in_position_flag_q <= droop_inside;
			holding_force_up_answer_q <= holding_force_up_request;
			redetect_request_q        <= redetect_request;
			redet_state_q             <= request_rise ? redet_running : redet_state_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_word_five <= 16'h0000;
			status_word_six  <= 16'h0000;
		end else begin
			status_word_five <= word_five_d;
			status_word_six  <= word_six_d;
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	logic [11:0] aw_addr_q;
	logic        aw_held_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_held_q;

	wire logic       aw_take;
	wire logic       w_take;
	wire logic       write_go;
	wire logic       hit_speed;
	wire logic       hit_hyst;
	wire logic       hit_area;
	wire logic       hit_ctrl;
	wire logic       hit_ro;
	wire logic [31:0] byte_mask;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign write_go = aw_held_q && w_held_q;
	assign hit_speed = aw_addr_q == `OFS_DETECT_SPEED;
	assign hit_hyst = aw_addr_q == `OFS_DETECT_HYST;
	assign hit_area = aw_addr_q == `OFS_IN_POS_AREA;
	assign hit_ctrl = aw_addr_q == `OFS_CONTROL;
	assign hit_ro = aw_addr_q == `OFS_STATUS_FIVE || aw_addr_q == `OFS_STATUS_SIX;
	assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
		{8{w_strb_q[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_addr_q <= 12'h000;
			aw_held_q <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			w_held_q  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
				aw_held_q <= 1'b1;
			end else if (write_go) begin
				aw_held_q <= 1'b0;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
			end else if (write_go) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			detect_speed_param_q      <= `RST_DETECT_SPEED;
			detect_hysteresis_param_q <= `RST_DETECT_HYST;
			in_pos_area_param_q       <= `RST_IN_POS_AREA;
			control_q                 <= `RST_CONTROL;
		end else if (write_go) begin
			if (hit_speed) begin
				detect_speed_param_q <= merge(detect_speed_param_q, w_data_q, byte_mask);
			end
			if (hit_hyst) begin
				detect_hysteresis_param_q <= merge(detect_hysteresis_param_q, w_data_q,
					byte_mask);
			end
			if (hit_area) begin
				in_pos_area_param_q <= merge(in_pos_area_param_q, w_data_q, byte_mask);
			end
			if (hit_ctrl && w_strb_q[0]) begin
				control_q <= w_data_q[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (write_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (hit_speed || hit_hyst || hit_area || hit_ctrl || hit_ro)
				? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	wire logic [11:0] rd_addr;
	wire logic        ar_take;
	wire logic        rd_known;
	wire logic [31:0] rd_value;

	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_addr = {s_axi_araddr[11:2], 2'b00};
	assign rd_known = rd_addr == `OFS_STATUS_FIVE || rd_addr == `OFS_STATUS_SIX
		|| rd_addr == `OFS_DETECT_SPEED || rd_addr == `OFS_DETECT_HYST
		|| rd_addr == `OFS_IN_POS_AREA || rd_addr == `OFS_CONTROL;
	assign rd_value = (rd_addr == `OFS_STATUS_FIVE) ? {16'h0000, status_word_five}
		: (rd_addr == `OFS_STATUS_SIX) ? {16'h0000, status_word_six}
		: (rd_addr == `OFS_DETECT_SPEED) ? detect_speed_param_q
		: (rd_addr == `OFS_DETECT_HYST) ? detect_hysteresis_param_q
		: (rd_addr == `OFS_IN_POS_AREA) ? in_pos_area_param_q
		: (rd_addr == `OFS_CONTROL) ? {28'h0000000, control_q}
		: 32'h0000_0000;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= resp_okay;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= rd_known ? resp_okay : resp_slverr;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ### verification/spindle_status_monitor.sv
// Port checker for the spindle status word generator
`timescale 1ns/100ps
module spindle_status_monitor (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        redetect_request,
	input wire logic        holding_force_up_request,
	input wire logic [15:0] status_word_five,
	input wire logic [15:0] status_word_six,
	input wire logic        redetect_start,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	maint_five_a: assert property ((status_word_five & 16'h07fd) == 16'h0000)
		else $error("word five spare bits set");
	maint_six_a: assert property ((status_word_six & 16'hfefe) == 16'h0000)
		else $error("word six spare bits set");
	hold_up_set_a: assert property (holding_force_up_request [*3] |-> status_word_five[14])
		else $error("holding force answer missing");
	hold_up_clr_a: assert property (!holding_force_up_request [*3] |-> !status_word_five[14])
		else $error("holding force answer stuck");
	redet_clear_a: assert property (!redetect_request [*3] |-> !status_word_five[13])
		else $error("re-detect flag not cleared");
	redet_cause_a: assert property ($rose(status_word_five[13]) |-> $past(redetect_request))
		else $error("re-detect flag without request");
	start_req_a: assert property ($rose(redetect_request) |-> redetect_start)
		else $error("request without start");
	read_done_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("read answer dropped early");
	write_done_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write answer dropped early");
	cover property ($rose(status_word_five[13]));
	cover property ($fell(status_word_five[1]));
	cover property ($rose(status_word_six[8]));
endmodule

bind spindle_status_word_gen spindle_status_monitor mon (.clk, .reset_n, .redetect_request,
	.holding_force_up_request, .status_word_five, .status_word_six, .redetect_start,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);

// ### verification/redetect_core_model.sv
// Re-detection core model answering a start with a finish pulse
`timescale 1ns/100ps
module redetect_core_model (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       redetect_start,
	input wire logic [3:0] delay,
	output logic           redetect_finished
);
	logic [3:0] count_q;
	logic       busy_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			count_q <= 4'h0;
			redetect_finished <= 1'b0;
		end else begin
			redetect_finished <= busy_q && count_q == 4'h0;
			if (redetect_start && !busy_q) begin
				busy_q <= 1'b1;
				count_q <= delay;
			end else if (busy_q && count_q != 4'h0) begin
				count_q <= count_q - 4'h1;
			end else begin
				busy_q <= 1'b0;
			end
		end
	end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the spindle status word generator
`timescale 1ns/100ps
module testbench;
	import spindle_status_pkg::*;
	logic               clk, reset_n, redetect_request, redetect_finished;
	logic               holding_force_up_request, redetect_start;
	logic signed [31:0] motor_speed, position_droop;
	logic [15:0]        status_word_five, status_word_six;
	logic [11:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata, rq;
	logic [3:0]         s_axi_wstrb, delay;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready;
	axi_resp_type       s_axi_bresp, s_axi_rresp, rr;
	int                 miscompares, check_count, i;
	int                 sp[8] = '{200, -50, -110, 120, 121, 100, 99, -121};
	int                 dr[5] = '{-10, 11, 10, -11, 0};
	spindle_status_word_gen dut (.clk, .reset_n, .motor_speed, .position_droop,
		.redetect_request, .redetect_finished, .holding_force_up_request, .status_word_five,
		.status_word_six, .redetect_start, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	redetect_core_model core (.clk, .reset_n, .redetect_start, .delay, .redetect_finished);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task summarize();
		if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task chkr(input axi_resp_type g, input axi_resp_type e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t response %b expected %b", $time, g, e);
		end
	endtask
	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Each valid drops at the edge its ready is seen; answer taken at the edge with its ready
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic done;
		int n;
		done = 1'b0;
		@(posedge clk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		for (n = 0; n < 20 && !done; n++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (w && s_axi_bvalid) begin
				done = 1'b1;
				rr = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
			if (!w && s_axi_rvalid) begin
				done = 1'b1;
				rq = s_axi_rdata;
				rr = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		if (!done) begin
			miscompares++;
			summarize();
		end
	endtask
	initial begin
		{reset_n, redetect_request, holding_force_up_request, delay} = '0;
		{motor_speed, position_droop, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		tk(5);
		reset_n <= 1'b1;
		xfer(0, 12'h014, 32'h0);
		chk(rq, 32'h0);
		chkr(rr, resp_okay);
		xfer(0, 12'h0f0, 32'h0);
		chkr(rr, resp_slverr);
		xfer(1, 12'h000, 32'hffff);
		chkr(rr, resp_okay);
		for (i = 0; i < 4; i++) begin
			xfer(1, 12'h014, 32'h1 << i);
			tk(4);
			chk(status_word_five[11], i == 0);
			chk(status_word_five[12], i == 1);
			xfer(0, 12'h004, 32'h0);
			chk(rq, {23'h0, i == 3, 7'h0, i == 2});
		end
		xfer(1, 12'h008, 32'd100);
		xfer(1, 12'h00c, 32'd20);
		xfer(1, 12'h010, 32'd10);
		for (i = 0; i < 8; i++) begin
			motor_speed <= sp[i];
			tk(4);
			chk(status_word_five[1], 8'h4e >> i & 1);
		end
		for (i = 0; i < 5; i++) begin
			position_droop <= dr[i];
			tk(4);
			chk(status_word_five[15], 5'h15 >> i & 1);
		end
		for (i = 0; i < 3; i++) begin
			holding_force_up_request <= !i[0];
			tk(4);
			chk(status_word_five[14], !i[0]);
		end
		for (i = 0; i < 2; i++) begin
			delay <= i ? 4'h9 : 4'h0;
			redetect_request <= 1'b1;
			tk(2);
			chk(status_word_five[13], 0);
			tk(16);
			chk(status_word_five[13], 1);
			redetect_request <= 1'b0;
			tk(4);
			chk(status_word_five[13], 0);
		end
		s_axi_wstrb <= 4'h2;
		xfer(1, 12'h008, 32'hffff_ff00);
		s_axi_wstrb <= 4'hf;
		xfer(0, 12'h008, 32'h0);
		chk(rq, 32'h0000_ff64);
		chk(status_word_five & 16'h07fd, 0);
		reset_n <= 1'b0;
		tk(2);
		reset_n <= 1'b1;
		chk(status_word_six, 16'h0000);
		xfer(0, 12'h014, 32'h0);
		chk(rq, 32'h0);
		summarize();
	end
endmodule
